// File: inc/cpl_pkg.sv
// Shared constants for the colour palette lookup ends
// Notes on behaviour
// RQ1: Select code chooses pointer, data, or mask
// RQ2: Red, green, blue writes store one entry
// RQ3: Pointer advances after each blue write
// RQ4: Three colour reads, pointer advances after blue
// RQ5: Colour on low six bits, upper read zero
// RQ6: Blue access at last entry wraps pointer
// RQ7: RAM transfers happen between host accesses
// RQ8: Host loads palette during blanking
// RQ9: Phase counter cycles red, green, blue
// RQ10: Pointer write clears phase, hidden from host
// RQ11: Pointer is eight bits, loaded whole
// RQ12: Pointer read changes no state
// RQ13: Pixel edge latches index, looks up entry
// RQ14: Blanking sampled with the pixel index
// RQ15: Index ANDed with mask before lookup
// RQ16: Mask readable and writable at any time
// RQ17: Latched blanking forces outputs to zero
// RQ18: Write data taken at strobe rising edge
// RQ19: Never both strobes low together
// RQ20: Pixel lookups win over host transfers
package cpl_pkg;
   localparam logic [1:0] SEL_PTR_WR = 2'h0;
   localparam logic [1:0] SEL_DATA = 2'h1;
   localparam logic [1:0] SEL_MASK = 2'h2;
   localparam logic [1:0] SEL_PTR_RD = 2'h3;
   localparam logic [1:0] PH_RED = 2'h0;
   localparam logic [1:0] PH_GREEN = 2'h1;
   localparam logic [1:0] PH_BLUE = 2'h2;
   localparam logic [7:0] PTR_FIRST = 8'h00;
   localparam logic [7:0] PTR_LAST = 8'hff;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hff;
   localparam logic [7:0] BUS_FLOAT = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int ENTRIES = 256;
   localparam int COLOR_W = 6;
   localparam int WORD_W = 18;
   localparam int RED_LSB = 12;
   localparam int GRN_LSB = 6;
   localparam int BLU_LSB = 0;
   localparam logic [5:0] COLOR_ZERO = 6'h00;
   localparam logic [1:0] PAD_ZERO = 2'h0;
   localparam logic [17:0] WORD_ZERO = 18'h00000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int STROBE_NS = 75;
   localparam int GAP_NS = 100;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] STROBE_LAST = 3'(STROBE_CYC - 1);
   localparam logic [2:0] GAP_LAST = 3'(GAP_CYC - 1);
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam int PIX_HALF_CYC = 2;
   localparam logic [1:0] PIX_HALF_LAST = 2'(PIX_HALF_CYC - 1);
   localparam logic [1:0] DIV_ZERO = 2'h0;
   localparam logic [1:0] DIV_ONE = 2'h1;
   localparam logic [7:0] PTR_ONE = 8'h01;
   localparam logic [1:0] PH_ONE = 2'h1;
endpackage

// File: inc/cpl_link_if.sv
// Pins between host bus and pixel source and the palette device
`timescale 1ns/1ps
`default_nettype none
interface cpl_link_if;
   logic register_select_lo;
   logic register_select_hi;
   logic read_strobe_n;
   logic write_strobe_n;
   logic [7:0] host_bus_out;
   logic host_bus_oe_n;
   logic [7:0] dev_bus_out;
   logic dev_bus_oe_n;
   logic [7:0] mpu_bus;
   logic pixel_clock;
   logic [7:0] pixel_index;
   logic blank_n;

   // Resolved bus level, pulled up when nobody drives
   assign mpu_bus = !dev_bus_oe_n ? dev_bus_out :
                    (!host_bus_oe_n ? host_bus_out : cpl_pkg::BUS_FLOAT);

   modport dev (
      input register_select_lo,
      input register_select_hi,
      input read_strobe_n,
      input write_strobe_n,
      input mpu_bus,
      input pixel_clock,
      input pixel_index,
      input blank_n,
      output dev_bus_out,
      output dev_bus_oe_n
   );

   modport host (
      output register_select_lo,
      output register_select_hi,
      output read_strobe_n,
      output write_strobe_n,
      output host_bus_out,
      output host_bus_oe_n,
      output pixel_clock,
      output pixel_index,
      output blank_n,
      input mpu_bus
   );
endinterface
`default_nettype wire

// File: verilog/cpl_host.sv
// Host bus master and pixel source end
`timescale 1ns/1ps
`default_nettype none
module cpl_host
   import cpl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   cpl_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [1:0] cmd_select,
   input wire logic [7:0] cmd_data,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   input wire logic [7:0] pix_index,
   input wire logic pix_blank_n,
   output logic pix_taken
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_GAP} cpl_hstate_e;

   cpl_hstate_e state_r;
   logic [2:0] cnt_r;
   logic write_r;
   logic [1:0] sel_r;
   logic [7:0] data_r;
   logic [1:0] div_r;
   logic pclk_r;
   logic [7:0] pix_r;
   logic blank_r;

   assign cmd_ready = (state_r == H_IDLE);

   // Only one strobe can be low, decoded from one state
   assign link.read_strobe_n = !(state_r == H_STROBE && !write_r); // see RQ19
   assign link.write_strobe_n = !(state_r == H_STROBE && write_r); // see RQ18
   assign link.register_select_lo = sel_r[0]; // see RQ1
   assign link.register_select_hi = sel_r[1];
   assign link.host_bus_out = data_r;
   assign link.host_bus_oe_n = !(write_r && state_r != H_IDLE && state_r != H_GAP);
   assign link.pixel_clock = pclk_r;
   assign link.pixel_index = pix_r;
   assign link.blank_n = blank_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= H_IDLE;
         cnt_r <= CNT_ZERO;
      end else begin
         case (state_r)
            H_IDLE: begin
               if (cmd_valid) begin
                  state_r <= H_SETUP;
               end
            end
            H_SETUP: begin
               state_r <= H_STROBE;
               cnt_r <= STROBE_LAST;
            end
            H_STROBE: begin
               if (cnt_r == CNT_ZERO) begin
                  state_r <= H_HOLD;
               end else begin
                  cnt_r <= cnt_r - CNT_ONE;
               end
            end
            H_HOLD: begin
               state_r <= H_GAP;
               cnt_r <= GAP_LAST;
            end
            H_GAP: begin
               if (cnt_r == CNT_ZERO) begin
                  state_r <= H_IDLE;
               end else begin
                  cnt_r <= cnt_r - CNT_ONE;
               end
            end
            default: begin
               state_r <= H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         write_r <= 1'b0;
         sel_r <= SEL_PTR_WR;
         data_r <= BYTE_ZERO;
      end else if (state_r == H_IDLE && cmd_valid) begin
         write_r <= cmd_write;
         sel_r <= cmd_select;
         data_r <= cmd_data;
      end
   end

   // Sample read data on the last strobe-low cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_data <= BYTE_ZERO;
      end else begin
         rsp_valid <= 1'b0;
         if (state_r == H_STROBE && cnt_r == CNT_ZERO && !write_r) begin
            rsp_valid <= 1'b1;
            rsp_data <= link.mpu_bus;
         end
      end
   end

   // Pixel clock divider; new pixel presented on the falling edge
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= DIV_ZERO;
         pclk_r <= 1'b0;
         pix_r <= BYTE_ZERO;
         blank_r <= 1'b0;
         pix_taken <= 1'b0;
      end else begin
         pix_taken <= 1'b0;
         if (div_r == PIX_HALF_LAST) begin
            div_r <= DIV_ZERO;
            pclk_r <= !pclk_r;
            if (pclk_r) begin
               pix_r <= pix_index;
               blank_r <= pix_blank_n;
               pix_taken <= 1'b1;
            end
         end else begin
            div_r <= div_r + DIV_ONE;
         end
      end
   end
endmodule
`default_nettype wire

// File: verilog/cpl_device.sv
// Palette device end: host registers, palette RAM and pixel lookup
`timescale 1ns/1ps
`default_nettype none
module cpl_device
   import cpl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   cpl_link_if.dev link,
   output logic [5:0] dac_red,
   output logic [5:0] dac_green,
   output logic [5:0] dac_blue,
   output logic dac_blank_n
);
   logic [WORD_W-1:0] pal_mem [0:ENTRIES-1];

   logic [7:0] pointer_r;
   logic [7:0] pointer_nxt;
   logic [1:0] phase_r;
   logic [7:0] mask_r;
   logic mode_read_r;
   logic [1:0] sel_r;
   logic [7:0] wr_data_r;
   logic wr_prev_r;
   logic rd_prev_r;
   logic pclk_prev_r;
   logic [5:0] wr_red_r;
   logic [5:0] wr_grn_r;
   logic [WORD_W-1:0] wr_word_r;
   logic [7:0] wr_addr_r;
   logic wr_pend_r;
   logic rd_pend_r;
   logic [WORD_W-1:0] fetch_r;
   logic [7:0] rd_data_r;
   logic [1:0] live_sel;
   logic wr_rise;
   logic rd_rise;
   logic ptr_wr;
   logic data_acc;
   logic blue_acc;
   logic blue_wr;
   logic mask_wr;
   logic fetch_req;
   logic pix_edge;
   logic ram_wr_go;
   logic ram_rd_go;
   logic [7:0] pix_addr;
   logic [WORD_W-1:0] pix_word;
   logic [5:0] fetch_color;

   assign live_sel = {link.register_select_hi, link.register_select_lo};

   // End of a host access is the strobe's rising edge
   assign wr_rise = link.write_strobe_n && !wr_prev_r; // see RQ18
   assign rd_rise = link.read_strobe_n && !rd_prev_r;

   // Access decode from the select captured during the access
   assign ptr_wr = wr_rise && (sel_r == SEL_PTR_WR || sel_r == SEL_PTR_RD); // see RQ1
   assign mask_wr = wr_rise && (sel_r == SEL_MASK); // see RQ16
   assign data_acc = (wr_rise || rd_rise) && (sel_r == SEL_DATA);
   assign blue_acc = data_acc && (phase_r == PH_BLUE);
   assign blue_wr = blue_acc && wr_rise;
   assign fetch_req = (ptr_wr && sel_r == SEL_PTR_RD) || (blue_acc && mode_read_r);

   // Pixel edge owns the RAM; host transfers wait for a free cycle
   assign pix_edge = link.pixel_clock && !pclk_prev_r;
   assign ram_wr_go = wr_pend_r && !pix_edge; // see RQ20
   assign ram_rd_go = rd_pend_r && !wr_pend_r && !pix_edge; // see RQ7

   assign pix_addr = link.pixel_index & mask_r; // see RQ15
   assign pix_word = pal_mem[pix_addr];

   // Last entry wraps to the first
   assign pointer_nxt = (pointer_r == PTR_LAST) ? PTR_FIRST : pointer_r + PTR_ONE; // see RQ6

   assign link.dev_bus_out = rd_data_r;
   assign link.dev_bus_oe_n = link.read_strobe_n || !link.write_strobe_n;

   always_comb begin
      case (phase_r)
         PH_RED: begin
            fetch_color = fetch_r[RED_LSB +: COLOR_W];
         end
         PH_GREEN: begin
            fetch_color = fetch_r[GRN_LSB +: COLOR_W];
         end
         default: begin
            fetch_color = fetch_r[BLU_LSB +: COLOR_W];
         end
      endcase
   end

   // Strobe and pixel clock history for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_prev_r <= 1'b1;
         rd_prev_r <= 1'b1;
         pclk_prev_r <= 1'b0;
      end else begin
         wr_prev_r <= link.write_strobe_n;
         rd_prev_r <= link.read_strobe_n;
         pclk_prev_r <= link.pixel_clock;
      end
   end

   // Select follows the bus while either strobe is low, write data only while the write strobe is low
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_r <= SEL_PTR_WR;
         wr_data_r <= BYTE_ZERO;
      end else begin
         if (!link.read_strobe_n || !link.write_strobe_n) begin
            sel_r <= live_sel;
         end
         if (!link.write_strobe_n) begin
            wr_data_r <= link.mpu_bus; // see RQ18
         end
      end
   end

   // Palette pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         pointer_r <= PTR_RESET;
      end else if (ptr_wr) begin
         pointer_r <= wr_data_r; // see RQ11
      end else if (blue_acc) begin
         pointer_r <= pointer_nxt; // see RQ3, see RQ4
      end
   end

   // Read or write mode set by the pointer write code
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_read_r <= 1'b0;
      end else if (ptr_wr) begin
         mode_read_r <= (sel_r == SEL_PTR_RD);
      end
   end

   // Hidden colour phase, never on the bus
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_r <= PH_RED;
      end else if (ptr_wr) begin
         phase_r <= PH_RED; // see RQ10
      end else if (data_acc) begin
         phase_r <= (phase_r == PH_BLUE) ? PH_RED : phase_r + PH_ONE; // see RQ9
      end
   end

   // Pixel mask
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r <= MASK_RESET;
      end else if (mask_wr) begin
         mask_r <= wr_data_r; // see RQ16
      end
   end

   // Colour holding registers for host writes
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_red_r <= COLOR_ZERO;
         wr_grn_r <= COLOR_ZERO;
         wr_word_r <= WORD_ZERO;
         wr_addr_r <= PTR_RESET;
      end else if (wr_rise && sel_r == SEL_DATA) begin
         case (phase_r)
            PH_RED: begin
               wr_red_r <= wr_data_r[COLOR_W-1:0]; // see RQ5
            end
            PH_GREEN: begin
               wr_grn_r <= wr_data_r[COLOR_W-1:0];
            end
            PH_BLUE: begin
               wr_word_r <= {wr_red_r, wr_grn_r, wr_data_r[COLOR_W-1:0]}; // see RQ2
               wr_addr_r <= pointer_r;
            end
            default: begin
               wr_red_r <= wr_red_r;
            end
         endcase
      end
   end

   // Deferred RAM transfers; a new request beats a completion
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= blue_wr || (wr_pend_r && !ram_wr_go); // see RQ7
         rd_pend_r <= fetch_req || (rd_pend_r && !ram_rd_go);
      end
   end

   always_ff @(posedge clk) begin
      if (ram_wr_go) begin
         pal_mem[wr_addr_r] <= wr_word_r; // see RQ2
      end
   end

   // Read holding register filled from the current pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_r <= WORD_ZERO;
      end else if (ram_rd_go) begin
         fetch_r <= pal_mem[pointer_r]; // see RQ4
      end
   end

   // Read data follows the selected register while reading
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_r <= BYTE_ZERO;
      end else if (!link.read_strobe_n) begin
         case (live_sel)
            SEL_PTR_WR: begin
               rd_data_r <= pointer_r; // see RQ12
            end
            SEL_PTR_RD: begin
               rd_data_r <= pointer_r; // see RQ12
            end
            SEL_DATA: begin
               rd_data_r <= {PAD_ZERO, fetch_color}; // see RQ5
            end
            SEL_MASK: begin
               rd_data_r <= mask_r; // see RQ16
            end
            default: begin
               rd_data_r <= BYTE_ZERO;
            end
         endcase
      end
   end

   // Pixel lookup on the pixel clock's rising edge
   always_ff @(posedge clk) begin
      if (rst) begin
         dac_red <= COLOR_ZERO;
         dac_green <= COLOR_ZERO;
         dac_blue <= COLOR_ZERO;
         dac_blank_n <= 1'b0;
      end else if (pix_edge) begin
         dac_blank_n <= link.blank_n; // see RQ14
         if (link.blank_n) begin
            dac_red <= pix_word[RED_LSB +: COLOR_W]; // see RQ13
            dac_green <= pix_word[GRN_LSB +: COLOR_W];
            dac_blue <= pix_word[BLU_LSB +: COLOR_W];
         end else begin
            dac_red <= COLOR_ZERO; // see RQ17
            dac_green <= COLOR_ZERO;
            dac_blue <= COLOR_ZERO;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/cpl_assertions.sv
// Protocol checks on the link between host end and palette device
`timescale 1ns/1ps
`default_nettype none
module cpl_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic register_select_lo,
   input wire logic register_select_hi,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] host_bus_out,
   input wire logic host_bus_oe_n,
   input wire logic [7:0] dev_bus_out,
   input wire logic dev_bus_oe_n,
   input wire logic [7:0] mpu_bus,
   input wire logic pixel_clock,
   input wire logic [7:0] pixel_index,
   input wire logic blank_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wr_low;
      !write_strobe_n [*3] ##1 write_strobe_n;
   endsequence
   sequence s_rd_low;
      !read_strobe_n [*3] ##1 read_strobe_n;
   endsequence

   // Device must stay off the bus while the host drives it
   property p_dev_drive;
      !host_bus_oe_n |-> dev_bus_oe_n;
   endproperty
   property p_color_pad;
      !read_strobe_n && $past(!read_strobe_n) && {register_select_hi, register_select_lo} == 2'h1
         |-> mpu_bus[7:6] == 2'h0;
   endproperty
   property p_one_strobe;
      read_strobe_n || write_strobe_n;
   endproperty
   property p_wr_pulse;
      $fell(write_strobe_n) |-> s_wr_low;
   endproperty
   property p_rd_pulse;
      $fell(read_strobe_n) |-> s_rd_low;
   endproperty
   property p_wr_hold;
      !write_strobe_n |-> !host_bus_oe_n && $stable(host_bus_out)
         && $stable({register_select_hi, register_select_lo});
   endproperty
   property p_gap;
      $rose(read_strobe_n) || $rose(write_strobe_n) |-> (read_strobe_n && write_strobe_n) [*3];
   endproperty
   property p_pix_clk;
      $rose(pixel_clock) |-> pixel_clock [*2] ##1 !pixel_clock [*2] ##1 pixel_clock;
   endproperty
   property p_pix_stable;
      pixel_clock |-> $stable(pixel_index) && $stable(blank_n);
   endproperty

   a_dev_drive: assert property (p_dev_drive)
      else $error("device drives the bus during a host write");
   a_color_pad: assert property (p_color_pad)
      else $error("colour read upper bits not zero");
   a_one_strobe: assert property (p_one_strobe)
      else $error("both strobes low");
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe pulse length wrong");
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe pulse length wrong");
   a_wr_hold: assert property (p_wr_hold)
      else $error("write data or select moved under strobe");
   a_gap: assert property (p_gap)
      else $error("gap between host accesses too short");
   a_pix_clk: assert property (p_pix_clk)
      else $error("pixel clock shape wrong");
   a_pix_stable: assert property (p_pix_stable)
      else $error("pixel index or blank moved while pixel clock high");
endmodule
`default_nettype wire

// File: bench/color_palette_lookup_tb.sv
// Self-checking bench for the host end and palette device pair
`timescale 1ns/1ps
`default_nettype none
module color_palette_lookup_tb
   import cpl_pkg::*;
;
   logic clk, rst, cmd_valid, cmd_ready, cmd_write, rsp_valid, pix_blank_n, pix_taken;
   logic dac_blank_n, pix_chk, pc_q, pend, pb_q, fill_blank;
   logic [1:0] cmd_select;
   logic [7:0] cmd_data, rsp_data, pix_index, ptr, mask, pi_q;
   logic [5:0] dac_red, dac_green, dac_blue;
   logic [5:0] col [3];
   logic [17:0] ram [256];
   logic [31:0] rnd;
   int ph, n_mismatch, samples_checked;

   cpl_link_if link ();
   cpl_host cpl_host_i (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_select(cmd_select),
      .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .pix_index(pix_index), .pix_blank_n(pix_blank_n), .pix_taken(pix_taken));
   cpl_device cpl_device_i (.clk(clk), .rst(rst), .link(link), .dac_red(dac_red),
      .dac_green(dac_green), .dac_blue(dac_blue), .dac_blank_n(dac_blank_n));
   cpl_assertions cpl_assertions_i (.clk(clk), .rst(rst),
      .register_select_lo(link.register_select_lo), .register_select_hi(link.register_select_hi),
      .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
      .host_bus_out(link.host_bus_out), .host_bus_oe_n(link.host_bus_oe_n),
      .dev_bus_out(link.dev_bus_out), .dev_bus_oe_n(link.dev_bus_oe_n),
      .mpu_bus(link.mpu_bus), .pixel_clock(link.pixel_clock),
      .pixel_index(link.pixel_index), .blank_n(link.blank_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function logic [7:0] nxt();
      rnd = {rnd[30:0], 1'b0} ^ (rnd[31] ? 32'h04c11db7 : 32'h0);
      return rnd[7:0];
   endfunction

   function logic [7:0] exp_rd(input logic [1:0] s);
      if (s == SEL_MASK) return mask;
      if (s == SEL_DATA) return {PAD_ZERO, 6'(ram[ptr] >> (12 - 6 * ph))};
      return ptr;
   endfunction

   function logic [18:0] exp_pix(input logic [7:0] i, input logic b);
      return b ? {1'b1, ram[i & mask]} : 19'h00000;
   endfunction

   task chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_pix(input logic [18:0] got, input logic [18:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One host access, entered at a falling edge with the host idle
   task acc(input logic w, input logic [1:0] s, input logic [7:0] d);
      logic [7:0] e;
      logic [7:0] q;
      int n;
      e = exp_rd(s);
      q = 8'h00;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_select = s;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 40) begin
         if (rsp_valid === 1'b1) q = rsp_data;
         @(negedge clk);
         n++;
      end
      if (n >= 40) n_mismatch++;
      if (!w) chk8(q, e);
      if (s == SEL_MASK && w) mask = d;
      if ((s == SEL_PTR_WR || s == SEL_PTR_RD) && w) begin
         ptr = d;
         ph = 0;
      end
      if (s == SEL_DATA) begin
         if (w) col[ph] = d[5:0];
         if (w && ph == 2) ram[ptr] = {col[0], col[1], col[2]};
         if (ph == 2) ptr = ptr + 8'h01;
         ph = (ph + 1) % 3;
      end
   endtask

   always @(negedge clk) begin
      pix_index <= nxt();
      pix_blank_n <= (rnd[11:9] != 3'h0) && !fill_blank;
   end

   // Compare outputs one edge after each pixel clock rise
   always @(negedge clk) begin
      if (pend && pix_chk) chk_pix({dac_blank_n, dac_red, dac_green, dac_blue}, exp_pix(pi_q, pb_q));
      // Host must present exactly the pixel and blank it took
      if (pix_taken) chk_pix({10'h000, link.blank_n, link.pixel_index}, {10'h000, pix_blank_n, pix_index});
      pend = link.pixel_clock && !pc_q;
      pc_q = link.pixel_clock;
      pi_q = link.pixel_index;
      pb_q = link.blank_n;
   end

   initial begin
      #(40000 * 25);
      n_mismatch++;
      end_sim();
   end

   initial begin
      rnd = 32'hfffaf83d;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_select = 2'h0;
      cmd_data = 8'h00;
      pix_index = 8'h00;
      pix_blank_n = 1'b0;
      pix_chk = 1'b0;
      fill_blank = 1'b0;
      pc_q = 1'b0;
      pend = 1'b0;
      ptr = PTR_RESET;
      mask = MASK_RESET;
      ph = 0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      acc(1'b0, SEL_PTR_RD, 8'h00);
      acc(1'b0, SEL_MASK, 8'h00);
      $display("Test reset done");
      // Palette loads only while the pixel stream is blanked
      fill_blank = 1'b1;
      acc(1'b1, SEL_PTR_WR, PTR_FIRST);
      for (int i = 0; i < 3 * ENTRIES; i++) acc(1'b1, SEL_DATA, nxt());
      acc(1'b0, SEL_PTR_WR, 8'h00);
      acc(1'b1, SEL_DATA, nxt());
      acc(1'b1, SEL_DATA, nxt());
      acc(1'b1, SEL_PTR_WR, PTR_LAST);
      for (int i = 0; i < 3; i++) acc(1'b1, SEL_DATA, nxt());
      acc(1'b0, SEL_PTR_RD, 8'h00);
      $display("Test fill done");
      fill_blank = 1'b0;
      // Readback while pixel lookups keep running
      pix_chk = 1'b1;
      acc(1'b1, SEL_PTR_RD, nxt());
      for (int i = 0; i < 30; i++) begin
         acc(1'b0, SEL_DATA, 8'h00);
         if (i % 7 == 3) acc(1'b0, SEL_PTR_RD, 8'h00);
      end
      acc(1'b0, SEL_PTR_RD, 8'h00);
      acc(1'b1, SEL_PTR_RD, PTR_LAST);
      for (int i = 0; i < 4; i++) acc(1'b0, SEL_DATA, 8'h00);
      acc(1'b0, SEL_PTR_WR, 8'h00);
      $display("Test readback done");
      for (int i = 0; i < 4; i++) begin
         pix_chk = 1'b0;
         acc(1'b1, SEL_MASK, (i == 1) ? BYTE_ZERO : (i == 3) ? MASK_RESET : nxt());
         pix_chk = 1'b1;
         acc(1'b0, SEL_MASK, 8'h00);
         repeat (200) @(negedge clk);
      end
      $display("Test mask done");
      end_sim();
   end
endmodule
`default_nettype wire
